// ### ccbo_exec.sv
// Function
// - AND-not-bit: two bytes, two cycles, C&=~bit
// - Source bit untouched, only carry changes
// - Compare branches on inequality, PC+3+rel
// - Carry set when first below second
// - Four compare operand pairings supported
// - Register compare: 10111rrr, three bytes, two cycles
// - Indirect compare: 1011011i, three bytes, two cycles
// - Zero accumulator, flags kept, one byte/cycle
// - Zero carry or bit; bit form c2
// - Invert accumulator, flags kept, one byte/cycle
// - Invert bit b2 two bytes; carry form one
// - Port read-modify-write uses output latch
// - Low nibble over nine or half-carry adds six
// - High nibble over nine or carry adds 60h
// - BCD adjust only sets carry, overflow kept
// - Minus one wraps 00h to ffh, no flags
// - Minus one on acc, reg, direct, indirect
`timescale 1ns/1ps
module ccbo_exec
	import ccbo_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic start_in,
	input wire ccbo_instr_t instr_in,
	input wire ccbo_opnd_t opnd_in,
	output logic busy_out,
	output logic done_out,
	output logic bad_opcode_out,
	output ccbo_result_t result_out
);
	function automatic ccbo_class_t decode_fn(input logic [7:0] op);
		ccbo_class_t c;
		c = CLS_BAD;
		if (op == OPC_AND_NBIT) begin
			c = CLS_AND_NBIT;
		end else if (op == OPC_CMP_AIMM) begin
			c = CLS_CMP_AIMM;
		end else if (op == OPC_CMP_ADIR) begin
			c = CLS_CMP_ADIR;
		end else if ((op & MASK_IND) == OPC_CMP_IND) begin
			c = CLS_CMP_IND;
		end else if ((op & MASK_REG) == OPC_CMP_REG) begin
			c = CLS_CMP_REG;
		end else if (op == OPC_ZERO_A) begin
			c = CLS_ZERO_A;
		end else if (op == OPC_ZERO_C) begin
			c = CLS_ZERO_C;
		end else if (op == OPC_ZERO_BIT) begin
			c = CLS_ZERO_BIT;
		end else if (op == OPC_INV_A) begin
			c = CLS_INV_A;
		end else if (op == OPC_INV_C) begin
			c = CLS_INV_C;
		end else if (op == OPC_INV_BIT) begin
			c = CLS_INV_BIT;
		end else if (op == OPC_BCD) begin
			c = CLS_BCD;
		end else if (op == OPC_MINUS_A) begin
			c = CLS_MINUS_A;
		end else if (op == OPC_MINUS_DIR) begin
			c = CLS_MINUS_DIR;
		end else if ((op & MASK_IND) == OPC_MINUS_IND) begin
			c = CLS_MINUS_IND;
		end else if ((op & MASK_REG) == OPC_MINUS_REG) begin
			c = CLS_MINUS_REG;
		end
		return c;
	endfunction
	function automatic logic [1:0] len_fn(input ccbo_class_t c);
		if (c inside {CLS_CMP_AIMM, CLS_CMP_ADIR, CLS_CMP_IND,
				CLS_CMP_REG})
			return LEN_3;
		if (c inside {CLS_AND_NBIT, CLS_ZERO_BIT, CLS_INV_BIT,
				CLS_MINUS_DIR})
			return LEN_2;
		return LEN_1;
	endfunction
	function automatic logic cyc_fn(input ccbo_class_t c);
		return (c inside {CLS_AND_NBIT, CLS_CMP_AIMM, CLS_CMP_ADIR,
			CLS_CMP_IND, CLS_CMP_REG}) ? CYC_2 : CYC_1;
	endfunction
	// Returns {carry, adjusted acc}
	function automatic logic [8:0] bcd_fn(input logic [7:0] a,
			input logic c, input logic h);
		logic [8:0] t;
		logic cy;
		t = {1'b0, a};
		cy = c;
		if (a[3:0] > BCD_LIMIT || h) begin
			t = t + BCD_FIX_LO;
			cy = cy | t[8];
		end
		if (t[7:4] > BCD_LIMIT || cy) begin
			t = {1'b0, t[7:0]} + BCD_FIX_HI;
			cy = cy | t[8];
		end
		return {cy, t[7:0]};
	endfunction
	ccbo_state_t state_ff, nxt_state;
	logic busy_ff, nxt_busy;
	logic done_ff, nxt_done;
	logic bad_ff, nxt_bad;
	ccbo_class_t cls_ff, nxt_cls;
	ccbo_instr_t ins_ff, nxt_ins;
	ccbo_opnd_t opd_ff, nxt_opd;
	ccbo_result_t res_ff, nxt_res;
	ccbo_result_t exec_res;
	logic [7:0] cmp_a, cmp_b;
	logic [8:0] bcd_val;
	assign busy_out = busy_ff;
	assign done_out = done_ff;
	assign bad_opcode_out = bad_ff;
	assign result_out = res_ff;
	// Operand selection for compares
	always_comb begin
		cmp_a = opd_ff.working_reg;
		if (cls_ff == CLS_CMP_AIMM || cls_ff == CLS_CMP_ADIR) begin
			cmp_a = opd_ff.acc;
		end else if (cls_ff == CLS_CMP_IND) begin
			cmp_a = opd_ff.ind_val;
		end
		cmp_b = (cls_ff == CLS_CMP_ADIR) ? opd_ff.dir_val : ins_ff.byte1;
		bcd_val = bcd_fn(opd_ff.acc, opd_ff.carry, opd_ff.half_carry_flag);
	end
	always_comb begin
		exec_res = '0;
		exec_res.len = len_fn(cls_ff);
		exec_res.pc_next = opd_ff.pc + {14'h0000, exec_res.len};
		case (cls_ff)
			CLS_AND_NBIT: begin
				exec_res.carry_we = 1'b1;
				exec_res.carry = opd_ff.carry & ~opd_ff.bit_val;
			end
			CLS_CMP_AIMM, CLS_CMP_ADIR, CLS_CMP_IND, CLS_CMP_REG: begin
				exec_res.carry_we = 1'b1;
				exec_res.carry = cmp_a < cmp_b;
				exec_res.branch = cmp_a != cmp_b;
				if (exec_res.branch)
					exec_res.pc_next = exec_res.pc_next
						+ {{8{ins_ff.byte2[7]}}, ins_ff.byte2};
			end
			CLS_ZERO_A: begin
				exec_res.acc_we = 1'b1;
				exec_res.acc = RST_BYTE;
			end
			CLS_ZERO_C: begin
				exec_res.carry_we = 1'b1;
				exec_res.carry = 1'b0;
			end
			CLS_ZERO_BIT: begin
				exec_res.bit_we = 1'b1;
				exec_res.bit_addr = ins_ff.byte1;
				exec_res.bit_val = 1'b0;
			end
			CLS_INV_A: begin
				exec_res.acc_we = 1'b1;
				exec_res.acc = ~opd_ff.acc;
			end
			CLS_INV_C: begin
				exec_res.carry_we = 1'b1;
				exec_res.carry = ~opd_ff.carry;
			end
			CLS_INV_BIT: begin
				exec_res.bit_we = 1'b1;
				exec_res.bit_addr = ins_ff.byte1;
				exec_res.bit_val = opd_ff.bit_is_port ? ~opd_ff.bit_latch
					: ~opd_ff.bit_val;
			end
			CLS_BCD: begin
				exec_res.acc_we = 1'b1;
				exec_res.acc = bcd_val[7:0];
				exec_res.carry_we = 1'b1;
				exec_res.carry = bcd_val[8];
			end
			CLS_MINUS_A: begin
				exec_res.acc_we = 1'b1;
				exec_res.acc = opd_ff.acc - MINUS_STEP;
			end
			CLS_MINUS_REG: begin
				exec_res.byte_we = 1'b1;
				exec_res.byte_dst = DST_REG;
				exec_res.byte_addr = {5'h00, ins_ff.opcode[2:0]};
				exec_res.byte_data = opd_ff.working_reg - MINUS_STEP;
			end
			CLS_MINUS_DIR: begin
				exec_res.byte_we = 1'b1;
				exec_res.byte_dst = DST_DIR;
				exec_res.byte_addr = ins_ff.byte1;
				exec_res.byte_data = (opd_ff.dir_is_port ? opd_ff.dir_latch
					: opd_ff.dir_val) - MINUS_STEP;
			end
			CLS_MINUS_IND: begin
				exec_res.byte_we = 1'b1;
				exec_res.byte_dst = DST_IND;
				exec_res.byte_addr = {7'h00, ins_ff.opcode[0]};
				exec_res.byte_data = opd_ff.ind_val - MINUS_STEP;
			end
			default: ; // Unknown opcode: no writes, pc plus one
		endcase
	end
	always_comb begin
		nxt_state = state_ff;
		nxt_done = 1'b0;
		nxt_bad = bad_ff;
		nxt_cls = cls_ff;
		nxt_ins = ins_ff;
		nxt_opd = opd_ff;
		nxt_res = res_ff;
		case (state_ff)
			ST_IDLE: begin
				if (start_in) begin
					nxt_ins = instr_in;
					nxt_opd = opnd_in;
					nxt_cls = decode_fn(instr_in.opcode);
					nxt_state = ST_EXEC;
				end
			end
			ST_EXEC: begin
				nxt_res = exec_res;
				nxt_bad = cls_ff == CLS_BAD;
				if (cyc_fn(cls_ff) == CYC_2) begin
					nxt_state = ST_HOLD;
				end else begin
					nxt_done = 1'b1;
					nxt_state = ST_IDLE;
				end
			end
			ST_HOLD: begin
				nxt_done = 1'b1;
				nxt_state = ST_IDLE;
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
		nxt_busy = nxt_state != ST_IDLE;
	end
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state_ff <= ST_IDLE;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
			bad_ff <= 1'b0;
			cls_ff <= CLS_BAD;
			ins_ff <= '0;
			opd_ff <= '0;
			res_ff <= '0;
		end else begin
			state_ff <= nxt_state;
			busy_ff <= nxt_busy;
			done_ff <= nxt_done;
			bad_ff <= nxt_bad;
			cls_ff <= nxt_cls;
			ins_ff <= nxt_ins;
			opd_ff <= nxt_opd;
			res_ff <= nxt_res;
		end
	end
	property p_and_nbit_carry;
		@(posedge clk_in) disable iff (rst_in)
		done_ff && cls_ff == CLS_AND_NBIT |->
			res_ff.carry_we && res_ff.carry ==
			(opd_ff.carry & ~opd_ff.bit_val);
	endproperty
	a_and_nbit_carry: assert property (p_and_nbit_carry)
		else $error("and-not-bit carry wrong");
	property p_and_nbit_keep;
		@(posedge clk_in) disable iff (rst_in)
		done_ff && cls_ff == CLS_AND_NBIT |->
			!res_ff.bit_we && !res_ff.byte_we && !res_ff.acc_we;
	endproperty
	a_and_nbit_keep: assert property (p_and_nbit_keep)
		else $error("and-not-bit touched more than carry");
	property p_cmp_branch;
		@(posedge clk_in) disable iff (rst_in)
		done_ff && cls_ff inside {CLS_CMP_AIMM, CLS_CMP_ADIR, CLS_CMP_IND,
			CLS_CMP_REG} |-> res_ff.branch == (cmp_a != cmp_b) &&
			res_ff.pc_next == opd_ff.pc + 16'h0003 + (res_ff.branch ?
			{{8{ins_ff.byte2[7]}}, ins_ff.byte2} : 16'h0000);
	endproperty
	a_cmp_branch: assert property (p_cmp_branch)
		else $error("compare branch target wrong");
	property p_cmp_carry;
		@(posedge clk_in) disable iff (rst_in)
		done_ff && cls_ff inside {CLS_CMP_AIMM, CLS_CMP_ADIR, CLS_CMP_IND,
			CLS_CMP_REG} |-> res_ff.carry == (cmp_a < cmp_b) &&
			!res_ff.byte_we && !res_ff.acc_we;
	endproperty
	a_cmp_carry: assert property (p_cmp_carry)
		else $error("compare carry wrong or operand written");
	property p_cmp_two_cycles;
		@(posedge clk_in) disable iff (rst_in)
		start_in && !busy_ff && (instr_in.opcode[7:3] == OPC_CMP_REG[7:3]
			|| instr_in.opcode[7:2] == OPC_CMP_AIMM[7:2])
			|-> ##1 !done_ff [*2] ##1 done_ff && res_ff.len == LEN_3;
	endproperty
	a_cmp_two_cycles: assert property (p_cmp_two_cycles)
		else $error("compare timing or length wrong");
	property p_zero_acc;
		@(posedge clk_in) disable iff (rst_in)
		start_in && !busy_ff && instr_in.opcode == OPC_ZERO_A |->
			##2 done_ff && res_ff.acc_we && res_ff.acc == RST_BYTE &&
			!res_ff.carry_we && res_ff.len == LEN_1;
	endproperty
	a_zero_acc: assert property (p_zero_acc)
		else $error("accumulator clear wrong");
	property p_inv_acc;
		@(posedge clk_in) disable iff (rst_in)
		done_ff && cls_ff == CLS_INV_A |->
			res_ff.acc == ~opd_ff.acc && !res_ff.carry_we;
	endproperty
	a_inv_acc: assert property (p_inv_acc)
		else $error("accumulator invert wrong");
	property p_inv_bit_latch;
		@(posedge clk_in) disable iff (rst_in)
		done_ff && cls_ff == CLS_INV_BIT && opd_ff.bit_is_port |->
			res_ff.bit_we && res_ff.bit_val == ~opd_ff.bit_latch;
	endproperty
	a_inv_bit_latch: assert property (p_inv_bit_latch)
		else $error("port bit invert ignored latch");
	property p_bcd_carry_kept;
		@(posedge clk_in) disable iff (rst_in)
		done_ff && cls_ff == CLS_BCD && opd_ff.carry |-> res_ff.carry;
	endproperty
	a_bcd_carry_kept: assert property (p_bcd_carry_kept)
		else $error("bcd adjust cleared carry");
	property p_minus_wrap;
		@(posedge clk_in) disable iff (rst_in)
		done_ff && cls_ff == CLS_MINUS_A |->
			res_ff.acc == opd_ff.acc - MINUS_STEP && !res_ff.carry_we;
	endproperty
	a_minus_wrap: assert property (p_minus_wrap)
		else $error("accumulator minus one wrong");
endmodule // ccbo_exec

// ### ccbo_pkg.sv
package ccbo_pkg;

	// Opcodes and match masks
	localparam logic [7:0] OPC_AND_NBIT = 8'hb0;
	localparam logic [7:0] OPC_CMP_AIMM = 8'hb4;
	localparam logic [7:0] OPC_CMP_ADIR = 8'hb5;
	localparam logic [7:0] OPC_CMP_IND = 8'hb6;
	localparam logic [7:0] OPC_CMP_REG = 8'hb8;
	localparam logic [7:0] OPC_ZERO_A = 8'he4;
	localparam logic [7:0] OPC_ZERO_C = 8'hc3;
	localparam logic [7:0] OPC_ZERO_BIT = 8'hc2;
	localparam logic [7:0] OPC_INV_A = 8'hf4;
	localparam logic [7:0] OPC_INV_C = 8'hb3;
	localparam logic [7:0] OPC_INV_BIT = 8'hb2;
	localparam logic [7:0] OPC_BCD = 8'hd4;
	localparam logic [7:0] OPC_MINUS_A = 8'h14;
	localparam logic [7:0] OPC_MINUS_DIR = 8'h15;
	localparam logic [7:0] OPC_MINUS_IND = 8'h16;
	localparam logic [7:0] OPC_MINUS_REG = 8'h18;
	localparam logic [7:0] MASK_IND = 8'hfe;
	localparam logic [7:0] MASK_REG = 8'hf8;

	// Lengths in bytes, machine cycles
	localparam logic [1:0] LEN_1 = 2'h1;
	localparam logic [1:0] LEN_2 = 2'h2;
	localparam logic [1:0] LEN_3 = 2'h3;
	localparam logic CYC_1 = 1'b0;
	localparam logic CYC_2 = 1'b1;

	// Arithmetic constants
	localparam logic [3:0] BCD_LIMIT = 4'h9;
	localparam logic [8:0] BCD_FIX_LO = 9'h006;
	localparam logic [8:0] BCD_FIX_HI = 9'h060;
	localparam logic [7:0] MINUS_STEP = 8'h01;

	// Reset values and byte destinations
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_PC = 16'h0000;
	localparam logic [1:0] DST_REG = 2'h0;
	localparam logic [1:0] DST_DIR = 2'h1;
	localparam logic [1:0] DST_IND = 2'h2;

	typedef enum logic [4:0] {
		CLS_BAD = 5'b00000, CLS_AND_NBIT = 5'b00001,
		CLS_CMP_AIMM = 5'b00010, CLS_CMP_ADIR = 5'b00011,
		CLS_CMP_IND = 5'b00100, CLS_CMP_REG = 5'b00101,
		CLS_ZERO_A = 5'b00110, CLS_ZERO_C = 5'b00111,
		CLS_ZERO_BIT = 5'b01000, CLS_INV_A = 5'b01001,
		CLS_INV_C = 5'b01010, CLS_INV_BIT = 5'b01011,
		CLS_BCD = 5'b01100, CLS_MINUS_A = 5'b01101,
		CLS_MINUS_REG = 5'b01110, CLS_MINUS_DIR = 5'b01111,
		CLS_MINUS_IND = 5'b10000
	} ccbo_class_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00, ST_EXEC = 2'b01, ST_HOLD = 2'b10
	} ccbo_state_t;

	typedef struct packed {
		logic [7:0] opcode;
		logic [7:0] byte1;
		logic [7:0] byte2;
	} ccbo_instr_t;

	typedef struct packed {
		logic [15:0] pc;
		logic [7:0] acc;
		logic carry;
		logic half_carry_flag;
		logic [7:0] working_reg;
		logic [7:0] ind_val;
		logic [7:0] dir_val;
		logic [7:0] dir_latch;
		logic dir_is_port;
		logic bit_val;
		logic bit_latch;
		logic bit_is_port;
	} ccbo_opnd_t;

	typedef struct packed {
		logic acc_we;
		logic [7:0] acc;
		logic carry_we;
		logic carry;
		logic byte_we;
		logic [1:0] byte_dst;
		logic [7:0] byte_addr;
		logic [7:0] byte_data;
		logic bit_we;
		logic [7:0] bit_addr;
		logic bit_val;
		logic branch;
		logic [15:0] pc_next;
		logic [1:0] len;
	} ccbo_result_t;

endpackage

// ### ccbo_seq_model.sv
`timescale 1ns/1ps

module ccbo_seq_model
	import ccbo_pkg::*;
(
	input wire logic clk_in,
	input wire logic busy_in,
	output logic start_out,
	output ccbo_instr_t instr_out,
	output ccbo_opnd_t opnd_out
);
	initial begin
		start_out = 1'b0;
		instr_out = '0;
		opnd_out = '0;
	end

	// One request; lines scrambled once taken
	task automatic issue(input ccbo_instr_t ins, input ccbo_opnd_t op);
		@(negedge clk_in);
		while (busy_in !== 1'b0) @(negedge clk_in);
		start_out = 1'b1;
		instr_out = ins;
		opnd_out = op;
		@(negedge clk_in);
		start_out = 1'b0;
		instr_out = ~ins;
		opnd_out = ~op;
	endtask
endmodule // ccbo_seq_model

// ### cpu_compare_clear_bcd_ops_test.sv
`timescale 1ns/1ps

module cpu_compare_clear_bcd_ops_test;
	import ccbo_pkg::*;
	localparam logic [7:0] CMP_OPS [7] = '{OPC_CMP_AIMM, OPC_CMP_ADIR,
		OPC_CMP_IND, OPC_CMP_IND | 8'h01, OPC_CMP_REG, OPC_CMP_REG | 8'h03,
		OPC_CMP_REG | 8'h07};
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic start, busy, done, bad;
	ccbo_instr_t ins;
	ccbo_opnd_t opw;
	ccbo_opnd_t op;
	ccbo_result_t r;
	int n_errors = 0;
	int compares = 0;
	int cyc = 0;

	always #5 clk_in = ~clk_in;

	ccbo_seq_model ccbo_seq_model_i (.clk_in(clk_in), .busy_in(busy),
		.start_out(start), .instr_out(ins), .opnd_out(opw));
	ccbo_exec ccbo_exec_i (.clk_in(clk_in), .rst_in(rst_in),
		.start_in(start), .instr_in(ins), .opnd_in(opw), .busy_out(busy),
		.done_out(done), .bad_opcode_out(bad), .result_out(r));

	task automatic give_verdict();
		$display("compares=%0d n_errors=%0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			give_verdict();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Issue one instruction, count edges until completion
	task automatic run(input logic [7:0] opc, b1, b2, input int lat);
		int n;
		// Taking edge already passed when issue returns
		n = 1;
		ccbo_seq_model_i.issue('{opc, b1, b2}, op);
		while (done !== 1'b1 && n < 20) begin
			@(negedge clk_in);
			n++;
		end
		chk(n, lat);
		chk({busy, done}, 2'b01);
	endtask

	task automatic post(input logic [3:0] we, input logic [1:0] len,
		input logic [15:0] ex);
		chk({r.acc_we, r.carry_we, r.byte_we, r.bit_we}, we);
		chk({r.len, r.pc_next}, {len, 16'(op.pc + 16'(len) + ex)});
	endtask

	task automatic t_clear_invert();
		op = '0;
		op.pc = 16'h1234;
		op.acc = 8'h5c;
		op.carry = 1'b1;
		op.bit_is_port = 1'b1;
		op.bit_latch = 1'b1;
		run(OPC_ZERO_A, 8'h00, 8'h00, 2);
		post(4'b1000, 1, 16'h0000);
		chk(r.acc, 8'h00);
		run(OPC_INV_A, 8'h00, 8'h00, 2);
		post(4'b1000, 1, 16'h0000);
		chk(r.acc, 8'ha3);
		run(OPC_ZERO_C, 8'h00, 8'h00, 2);
		post(4'b0100, 1, 16'h0000);
		chk(r.carry, 1'b0);
		run(OPC_INV_C, 8'h00, 8'h00, 2);
		post(4'b0100, 1, 16'h0000);
		chk(r.carry, 1'b0);
		run(OPC_ZERO_BIT, 8'h92, 8'h00, 2);
		post(4'b0001, 2, 16'h0000);
		chk({r.bit_addr, r.bit_val}, {8'h92, 1'b0});
		run(OPC_INV_BIT, 8'h91, 8'h00, 2);
		post(4'b0001, 2, 16'h0000);
		chk({r.bit_addr, r.bit_val}, {8'h91, 1'b0});
		$display("test clear_invert done");
	endtask

	task automatic t_and_not();
		op = '0;
		op.pc = 16'h0ffe;
		for (int i = 0; i < 4; i++) begin
			op.carry = i[1];
			op.bit_val = i[0];
			op.bit_latch = ~i[0];
			run(OPC_AND_NBIT, 8'h20, 8'h00, 3);
			post(4'b0100, 2, 16'h0000);
			chk(r.carry, i[1] & ~i[0]);
		end
		$display("test and_not done");
	endtask

	task automatic t_compare();
		logic [7:0] f;
		logic ne;
		op = '0;
		op.pc = 16'h0100;
		op.dir_val = 8'h60;
		op.dir_latch = 8'h11;
		for (int k = 0; k < 7; k++) begin
			for (int j = 0; j < 3; j++) begin
				f = 8'h5f + 8'(j);
				ne = (f != 8'h60);
				op.acc = f;
				op.ind_val = f;
				op.working_reg = f;
				op.carry = ~ne;
				run(CMP_OPS[k], (k == 1) ? 8'h90 : 8'h60, 8'hf0, 3);
				post(4'b0100, 3, ne ? 16'hfff0 : 16'h0000);
				chk(r.branch, ne);
				chk(r.carry, f < 8'h60);
			end
		end
		$display("test compare done");
	endtask

	function automatic logic [8:0] bcd(input logic [7:0] a,
		input logic c, input logic h);
		logic [8:0] s;
		s = {1'b0, a};
		if (a[3:0] > 4'h9 || h)
			s = s + 9'h006;
		if (c || s[8] || s[7:4] > 4'h9)
			s = s + 9'h060;
		return {s[8] | c, s[7:0]};
	endfunction

	task automatic t_bcd();
		logic [9:0] tb [6] = '{{8'hbe, 2'b00}, {8'hc9, 2'b00},
			{8'h12, 2'b10}, {8'h19, 2'b01}, {8'h9a, 2'b00}, {8'h45, 2'b00}};
		op = '0;
		op.pc = 16'h0200;
		for (int i = 0; i < 6; i++) begin
			{op.acc, op.carry, op.half_carry_flag} = tb[i];
			run(OPC_BCD, 8'h00, 8'h00, 2);
			post(4'b1100, 1, 16'h0000);
			chk({r.carry, r.acc},
				bcd(op.acc, op.carry, op.half_carry_flag));
		end
		$display("test bcd done");
	endtask

	task automatic t_minus();
		op = '0;
		op.pc = 16'h0300;
		op.carry = 1'b1;
		op.working_reg = 8'h80;
		op.dir_val = 8'h33;
		op.dir_is_port = 1'b1;
		op.ind_val = 8'h40;
		run(OPC_MINUS_A, 8'h00, 8'h00, 2);
		post(4'b1000, 1, 16'h0000);
		chk(r.acc, 8'hff);
		run(OPC_MINUS_REG | 8'h07, 8'h00, 8'h00, 2);
		post(4'b0010, 1, 16'h0000);
		chk({r.byte_dst, r.byte_addr, r.byte_data}, {DST_REG, 16'h077f});
		run(OPC_MINUS_DIR, 8'h90, 8'h00, 2);
		post(4'b0010, 2, 16'h0000);
		chk({r.byte_dst, r.byte_addr, r.byte_data}, {DST_DIR, 16'h90ff});
		run(OPC_MINUS_IND | 8'h01, 8'h00, 8'h00, 2);
		post(4'b0010, 1, 16'h0000);
		chk({r.byte_dst, r.byte_addr, r.byte_data}, {DST_IND, 16'h013f});
		$display("test minus done");
	endtask

	task automatic t_bad();
		op = '0;
		op.pc = 16'hffff;
		run(8'ha5, 8'h00, 8'h00, 2);
		chk(bad, 1'b1);
		post(4'b0000, 1, 16'h0000);
		run(OPC_ZERO_A, 8'h00, 8'h00, 2);
		chk(bad, 1'b0);
		$display("test bad done");
	endtask

	// Reset in mid-instruction, then work resumes
	task automatic t_reset();
		op = '0;
		run(8'ha5, 8'h00, 8'h00, 2);
		chk(bad, 1'b1);
		ccbo_seq_model_i.issue('{OPC_CMP_AIMM, 8'h01, 8'h02}, op);
		rst_in = 1'b1;
		repeat (2) @(negedge clk_in);
		rst_in = 1'b0;
		chk({busy, done, bad}, 3'b000);
		chk(r[31:0], 32'h00000000);
		chk(32'(r >> 32), 32'h00000000);
		run(OPC_ZERO_A, 8'h00, 8'h00, 2);
		post(4'b1000, 1, 16'h0000);
		$display("test reset done");
	endtask

	initial begin
		op = '0;
		repeat (2) @(negedge clk_in);
		rst_in = 1'b0;
		t_clear_invert();
		t_and_not();
		t_compare();
		t_bcd();
		t_minus();
		t_bad();
		t_reset();
		give_verdict();
	end
endmodule // cpu_compare_clear_bcd_ops_test
